// ### design/eleu_pkg.sv
// ---------------------------------------------------------------------
// Shared constants and types of the external line unit.
// ---------------------------------------------------------------------
package eleu_pkg;

	// Number of external lines handled by the unit.
	localparam int ELEU_LINES = 10;

	// Byte addresses of the six registers on the system bus.
	localparam logic [31:0] ELEU_ADDR_INT_EN = 32'h4001_0400;
	localparam logic [31:0] ELEU_ADDR_EVT_EN = 32'h4001_0404;
	localparam logic [31:0] ELEU_ADDR_RISE = 32'h4001_0408;
	localparam logic [31:0] ELEU_ADDR_FALL = 32'h4001_040c;
	localparam logic [31:0] ELEU_ADDR_SWTRIG = 32'h4001_0410;
	localparam logic [31:0] ELEU_ADDR_PEND = 32'h4001_0414;

	// Reset values of the registers.
	localparam logic [9:0] ELEU_RST_INT_EN = 10'h000;
	localparam logic [9:0] ELEU_RST_EVT_EN = 10'h000;
	localparam logic [9:0] ELEU_RST_RISE = 10'h000;
	localparam logic [9:0] ELEU_RST_FALL = 10'h000;
	localparam logic [9:0] ELEU_RST_SWTRIG = 10'h000;
	localparam logic [9:0] ELEU_RST_PEND = 10'h000;

	// Field positions: channel 8 is the supply monitor, 9 the wake-up.
	localparam int ELEU_POS_PORT_MSB = 7;
	localparam int ELEU_POS_SUPPLY = 8;
	localparam int ELEU_POS_WAKE = 9;

	// Bus transfer type that starts a new transfer.
	localparam logic [1:0] ELEU_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] ELEU_HTRANS_SEQ = 2'h3;

	// One pending bus access, captured in its address phase.
	typedef struct packed {
		logic valid;
		logic write;
		logic [31:0] addr;
		logic [3:0] lanes;
	} eleu_access_t;

	// Per-channel configuration as seen by the trigger logic.
	typedef struct packed {
		logic [9:0] intEn;
		logic [9:0] evtEn;
		logic [9:0] riseEn;
		logic [9:0] fallEn;
	} eleu_cfg_t;

endpackage

// ### design/eleu_line_edge.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// Three-stage line synchroniser with qualified edge detection.
// ---------------------------------------------------------------------
module eleu_line_edge (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Asynchronous line from a pin or another block.
	input wire logic line,
	// Registered one-cycle edge pulses.
	output logic rise,
	output logic fall
);

	logic syncA; // First stage, read only by the second stage.
	logic syncB; // Second stage.
	logic syncC; // Third stage.
	logic level; // Accepted line level.
	logic agree; // Second and third stage agree.

	// Shift the line through three flops.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			syncC <= 1'b0;
		end else begin
			syncA <= line;
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	assign agree = (syncB == syncC);

	// Accept a new level only when the late stages agree, and flag edges.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			level <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			if (agree) begin
				level <= syncC;
			end
			rise <= agree & syncC & ~level;
			fall <= agree & ~syncC & level;
		end
	end

endmodule

// ### design/eleu_pend_flags.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// Sticky pending flags with write-one-to-clear; a set beats a clear.
// ---------------------------------------------------------------------
module eleu_pend_flags #(
	parameter int W = 10,
	parameter logic [W-1:0] RST = '0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Set and clear requests, one bit per flag.
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	// Flag state and the value it takes at the next edge.
	output logic [W-1:0] flags,
	output logic [W-1:0] next_flags
);

	// A bit is kept unless cleared, and always set by a trigger.
	assign next_flags = (flags & ~clr) | set;

	// Hold the flags.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			flags <= RST;
		end else begin
			flags <= next_flags;
		end
	end

endmodule

// ### design/eleu_line_unit.sv
`timescale 1ns/100ps
// Contract
// - Interrupt request forwarded only when enabled.
// - Event output only when event enabled.
// - Rising edge triggers when rising select set.
// - Falling edge triggers when falling select set.
// - Software trigger write of one sets pending.
// - Software trigger yields interrupt and event.
// - Pending flag stays set until software clears.
// - Writing one clears the pending flag.
// - Selected edge raises request and sets pending.
// - Edge OR software, gated by both enables.
// - Both edges may be selected together.
// - Lines 0-7 pins, 8 supply, 9 wake.
module eleu_line_unit
	import eleu_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// System bus slave, address phase.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	// System bus slave, data phase.
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Trigger sources.
	input wire logic [eleu_pkg::ELEU_POS_PORT_MSB:0] portLine,
	input wire logic supplyMonitorEvt,
	input wire logic autoWakeEvt,
	// Requests toward the core.
	output logic [eleu_pkg::ELEU_LINES-1:0] irqReq,
	output logic [eleu_pkg::ELEU_LINES-1:0] wakeEvt
);
	import eleu_pkg::*;

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	eleu_access_t access; // Address phase held for the data phase.
	eleu_access_t next_access; // Address phase being taken now.
	eleu_cfg_t cfg; // Enable and edge select registers.
	eleu_cfg_t next_cfg; // Their values after this edge.
	logic [9:0] swTrig; // Software trigger register.
	logic [9:0] next_swTrig; // Its value after this edge.
	logic [9:0] lineIn; // Raw source of each channel.
	logic [9:0] riseSeen; // Qualified rising edges.
	logic [9:0] fallSeen; // Qualified falling edges.
	logic [9:0] hwTrig; // Edge triggers allowed by the selects.
	logic [9:0] swPulse; // Bits written as one to the soft trigger.
	logic [9:0] trig; // Combined trigger per channel.
	logic [9:0] pendClr; // Bits written as one to the flag register.
	logic [9:0] pend; // Pending flags.
	logic [9:0] next_pend; // Pending flags after this edge.
	logic [9:0] wrData; // Write data merged through the byte lanes.
	logic [9:0] wrMask; // Bits covered by the active byte lanes.

	// -----------------------------------------------------------------
	// Trigger sources
	// -----------------------------------------------------------------

	// Ports feed 0-7, the supply monitor 8, automatic wake-up 9.
	assign lineIn = {autoWakeEvt, supplyMonitorEvt, portLine};

	// One synchroniser and edge detector per channel.
	for (genvar ch = 0; ch < ELEU_LINES; ch++) begin : gLine
		eleu_line_edge uEdge (
			.clk(clk),
			.rstn(rstn),
			.line(lineIn[ch]),
			.rise(riseSeen[ch]),
			.fall(fallSeen[ch])
		);
	end

	// Each edge counts only where its select is set; both may be set.
	assign hwTrig = (riseSeen & cfg.riseEn)
		| (fallSeen & cfg.fallEn);

	// Hardware and software triggers are merged before the enable gating.
	assign trig = hwTrig | swPulse;

	// -----------------------------------------------------------------
	// Bus slave
	// -----------------------------------------------------------------

	// Byte lanes of a transfer from its size and low address bits.
	function automatic logic [3:0] laneMask(input logic [2:0] size,
		input logic [1:0] low);
		logic [3:0] m;
		m = 4'h0;
		case (size)
			3'h0: m = 4'h1 << low;
			3'h1: m = low[1] ? 4'hc : 4'h3;
			default: m = 4'hf;
		endcase
		return m;
	endfunction

	// Capture a valid address phase for the following data phase.
	always_comb begin
		next_access.valid = hsel & hready
			& (htrans == ELEU_HTRANS_NONSEQ || htrans == ELEU_HTRANS_SEQ);
		next_access.write = hwrite;
		next_access.addr = {haddr[31:2], 2'h0};
		next_access.lanes = laneMask(hsize, haddr[1:0]);
	end

	// Hold the address phase.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			access <= '0;
		end else begin
			access <= next_access;
		end
	end

	// Only the low two byte lanes carry implemented bits.
	assign wrMask = {{2{access.lanes[1]}}, {8{access.lanes[0]}}};
	assign wrData = hwdata[9:0] & wrMask;

	// Work out the register values that this data phase leaves behind.
	always_comb begin
		next_cfg = cfg;
		next_swTrig = swTrig;
		swPulse = 10'h000;
		pendClr = 10'h000;
		if (access.valid && access.write) begin
			case (access.addr)
				ELEU_ADDR_INT_EN: begin
					next_cfg.intEn = (cfg.intEn & ~wrMask) | wrData;
				end
				ELEU_ADDR_EVT_EN: begin
					next_cfg.evtEn = (cfg.evtEn & ~wrMask) | wrData;
				end
				ELEU_ADDR_RISE: begin
					next_cfg.riseEn = (cfg.riseEn & ~wrMask) | wrData;
				end
				ELEU_ADDR_FALL: begin
					next_cfg.fallEn = (cfg.fallEn & ~wrMask) | wrData;
				end
				ELEU_ADDR_SWTRIG: begin
					next_swTrig = (swTrig & ~wrMask) | wrData;
					swPulse = wrData;
				end
				ELEU_ADDR_PEND: begin
					// Ones clear, zeros leave the flag alone.
					pendClr = wrData;
				end
				default: begin
					// Unmapped words ignore writes.
					next_swTrig = swTrig;
				end
			endcase
		end
	end

	// Store the configuration registers.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg.intEn <= ELEU_RST_INT_EN;
			cfg.evtEn <= ELEU_RST_EVT_EN;
			cfg.riseEn <= ELEU_RST_RISE;
			cfg.fallEn <= ELEU_RST_FALL;
			swTrig <= ELEU_RST_SWTRIG;
		end else begin
			cfg <= next_cfg;
			swTrig <= next_swTrig;
		end
	end

	// Pending flags: any trigger sets, a written one clears, set wins.
	eleu_pend_flags #(
		.W(ELEU_LINES),
		.RST(ELEU_RST_PEND)
	) uPend (
		.clk(clk),
		.rstn(rstn),
		.set(trig),
		.clr(pendClr),
		.flags(pend),
		.next_flags(next_pend)
	);

	// Read data is fetched in the address phase from post-write values,
	// so a read right after a write already sees the new contents.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (next_access.valid && !next_access.write) begin
			case (next_access.addr)
				ELEU_ADDR_INT_EN: hrdata <= {22'h00_0000, next_cfg.intEn};
				ELEU_ADDR_EVT_EN: hrdata <= {22'h00_0000, next_cfg.evtEn};
				ELEU_ADDR_RISE: hrdata <= {22'h00_0000, next_cfg.riseEn};
				ELEU_ADDR_FALL: hrdata <= {22'h00_0000, next_cfg.fallEn};
				ELEU_ADDR_SWTRIG: hrdata <= {22'h00_0000, next_swTrig};
				ELEU_ADDR_PEND: hrdata <= {22'h00_0000, next_pend};
				default: hrdata <= 32'h0000_0000;
			endcase
		end else begin
			hrdata <= 32'h0000_0000;
		end
	end

	// The slave never waits and never signals an error.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Outputs toward the core
	// -----------------------------------------------------------------

	// Interrupt request is a level: pending and enabled.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			irqReq <= 10'h000;
		end else begin
			irqReq <= next_pend & next_cfg.intEn;
		end
	end

	// Event is a one-cycle pulse per trigger, gated by its own enable.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wakeEvt <= 10'h000;
		end else begin
			wakeEvt <= trig & cfg.evtEn;
		end
	end

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------

	// A software-trigger write of ones on line 0.
	sequence swWrite0;
		access.valid && access.write && access.addr == ELEU_ADDR_SWTRIG
			&& wrData[0];
	endsequence

	// A flag-register write with a one on line 0, no trigger.
	sequence clrWrite0;
		access.valid && access.write && access.addr == ELEU_ADDR_PEND
			&& wrData[0] && !trig[0];
	endsequence

	a_irq_mask: assert property (@(posedge clk) disable iff (!rstn)
		!cfg.intEn[3] && !next_cfg.intEn[3] |=> !irqReq[3])
		else $error("masked line raised interrupt");

	a_evt_gate: assert property (@(posedge clk) disable iff (!rstn)
		trig[4] |=> wakeEvt[4] == $past(cfg.evtEn[4]))
		else $error("event gating wrong");

	a_rise_only: assert property (@(posedge clk) disable iff (!rstn)
		riseSeen[0] && !cfg.riseEn[0] && !swPulse[0] |-> !trig[0])
		else $error("unselected rising edge triggered");

	a_fall_sets: assert property (@(posedge clk) disable iff (!rstn)
		fallSeen[2] && cfg.fallEn[2] |=> pend[2])
		else $error("falling edge did not set flag");

	a_sw_trigger: assert property (@(posedge clk) disable iff (!rstn)
		swWrite0 |=> pend[0])
		else $error("soft trigger did not set flag");

	a_sw_irq: assert property (@(posedge clk) disable iff (!rstn)
		swWrite0 ##0 cfg.intEn[0] ##0 next_cfg.intEn[0] |=> irqReq[0])
		else $error("soft trigger gave no interrupt");

	a_pend_hold: assert property (@(posedge clk) disable iff (!rstn)
		pend[5] && !pendClr[5] |=> pend[5])
		else $error("pending flag dropped without clear");

	a_w1c_clear: assert property (@(posedge clk) disable iff (!rstn)
		clrWrite0 |=> !pend[0])
		else $error("write one did not clear flag");

	a_set_wins: assert property (@(posedge clk) disable iff (!rstn)
		trig[6] && pendClr[6] |=> pend[6])
		else $error("clear beat a simultaneous trigger");

	a_or_gate: assert property (@(posedge clk) disable iff (!rstn)
		hwTrig[3] && cfg.evtEn[3] |=> wakeEvt[3])
		else $error("hardware edge gave no event");

	a_both_edges: assert property (@(posedge clk) disable iff (!rstn)
		cfg.riseEn[3] && cfg.fallEn[3] && (riseSeen[3] || fallSeen[3])
			|=> pend[3])
		else $error("double edge missed");

	a_resv_zero: assert property (@(posedge clk) disable iff (!rstn)
		hrdata[31:10] == 22'h00_0000)
		else $error("reserved read bits not zero");

	a_irq_level: assert property (@(posedge clk) disable iff (!rstn)
		irqReq[8] |-> pend[8] && cfg.intEn[8])
		else $error("request without flag");

endmodule

// ### verification/eleu_core_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------------
// Core-side model: wake record only; the interrupt requests are not used.
// ---------------------------------------------------------------------
module eleu_core_model
	import eleu_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Requests from the unit.
	input wire logic [eleu_pkg::ELEU_LINES-1:0] irqReq,
	input wire logic [eleu_pkg::ELEU_LINES-1:0] wakeEvt,
	// Bench control and observation.
	input wire logic clrSeen,
	output logic [eleu_pkg::ELEU_LINES-1:0] seenEvt
);
	import eleu_pkg::*;
	// Wake pulses last one cycle, so each one is caught and held.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			seenEvt <= '0;
		end else if (clrSeen) begin
			// The bench empties the record between scenarios.
			seenEvt <= '0;
		end else begin
			seenEvt <= seenEvt | wakeEvt;
		end
	end
endmodule

// ### verification/eleu_line_unit_bench.sv
`timescale 1ns/100ps
module eleu_line_unit_bench;
	import eleu_pkg::*;
	// -----------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------
	logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, clrSeen;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [9:0] lines, irqReq, wakeEvt, seenEvt;
	int nErrors, samplesChecked;
	// One table row: access, read-back, request and wake record.
	typedef struct packed {
		logic [31:0] a;
		logic [31:0] d;
		logic [31:0] q;
		logic [9:0] irq;
		logic [9:0] ev;
	} eleu_row_t;
	eleu_row_t rows [9] = '{
		'{ELEU_ADDR_INT_EN, 32'hffffffff, 32'h3ff, 10'h000, 10'h000},
		'{ELEU_ADDR_EVT_EN, 32'h155, 32'h155, 10'h000, 10'h000},
		'{ELEU_ADDR_RISE, 32'h2aa, 32'h2aa, 10'h000, 10'h000},
		'{ELEU_ADDR_FALL, 32'hfffffc0f, 32'h00f, 10'h000, 10'h000},
		'{32'h40010418, 32'hffffffff, 32'h0, 10'h000, 10'h000},
		'{ELEU_ADDR_SWTRIG, 32'h3ff, 32'h3ff, 10'h3ff, 10'h155},
		'{ELEU_ADDR_PEND, 32'h0, 32'h3ff, 10'h3ff, 10'h155},
		'{ELEU_ADDR_PEND, 32'h3ff, 32'h0, 10'h000, 10'h155},
		'{ELEU_ADDR_SWTRIG, 32'h0, 32'h0, 10'h000, 10'h155}
	};
	// The interconnect feeds the slave's own ready back to it.
	assign hready = hreadyout;
	// -----------------------------------------------------------------
	// Design and core-side model
	// -----------------------------------------------------------------
	eleu_line_unit dut (
		.clk(clk),
		.rstn(rstn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.portLine(lines[7:0]),
		.supplyMonitorEvt(lines[8]),
		.autoWakeEvt(lines[9]),
		.irqReq(irqReq),
		.wakeEvt(wakeEvt)
	);
	eleu_core_model core (
		.clk(clk),
		.rstn(rstn),
		.irqReq(irqReq),
		.wakeEvt(wakeEvt),
		.clrSeen(clrSeen),
		.seenEvt(seenEvt)
	);
	// -----------------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------------
	// Compares one value and counts the comparison.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nErrors++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic conclude();
		$display("Checks %0d, errors %0d", samplesChecked, nErrors);
		if (nErrors == 0 && samplesChecked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Address phase, held until ready is seen high at an edge.
	task automatic req(input logic [31:0] a, input logic w);
		int n;
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= ELEU_HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= a;
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			if (hready === 1'b1) break;
		end
		if (n == 8) begin
			nErrors++;
			conclude();
		end
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask
	// Register write; the data phase ends at the following edge.
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		req(a, 1'b1);
		hwdata <= d;
		@(posedge clk);
	endtask
	// Register read; data is taken at the edge ending the data phase.
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		req(a, 1'b0);
		@(posedge clk);
		d = hrdata;
	endtask
	// Empties the wake record of the core model.
	task automatic clr();
		@(posedge clk);
		clrSeen <= 1'b1;
		@(posedge clk);
		clrSeen <= 1'b0;
	endtask
	// Drives all ten lines, then lets the sync chain settle.
	task automatic drive(input logic [9:0] v);
		@(posedge clk);
		lines <= v;
		repeat (8) @(posedge clk);
	endtask
	// -----------------------------------------------------------------
	// Clock and hang guard
	// -----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		nErrors++;
		conclude();
	end
	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		lines = 10'h000;
		clrSeen = 1'b0;
		nErrors = 0;
		samplesChecked = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		// All six registers start at zero.
		for (int i = 0; i < 6; i++) begin
			rd(ELEU_ADDR_INT_EN + 32'(4 * i), rdv);
			chk(rdv, 32'h0);
		end
		// Table rows: writes, read-back, requests and wake pulses.
		for (int i = 0; i < 9; i++) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rdv);
			chk(rdv, rows[i].q);
			chk(32'({hreadyout, hresp}), 32'h2);
			chk(32'(irqReq), 32'(rows[i].irq));
			chk(32'(seenEvt), 32'(rows[i].ev));
		end
		// Rising edges on all lines, enables deliberately partial.
		wr(ELEU_ADDR_INT_EN, 32'h0f0);
		wr(ELEU_ADDR_EVT_EN, 32'h30c);
		clr();
		drive(10'h3ff);
		rd(ELEU_ADDR_PEND, rdv);
		chk(rdv, 32'h2aa);
		chk(32'(irqReq), 32'h0a0);
		chk(32'(seenEvt), 32'h208);
		// Falling edges; lines 1 and 3 also catch the rising edge.
		wr(ELEU_ADDR_PEND, 32'h3ff);
		clr();
		drive(10'h000);
		rd(ELEU_ADDR_PEND, rdv);
		chk(rdv, 32'h00f);
		chk(32'(irqReq), 32'h0);
		chk(32'(seenEvt), 32'h00c);
		// Masking and unmasking leaves the flags standing.
		// The request register follows the edge at which the write lands,
		// so one more edge passes before it is looked at.
		wr(ELEU_ADDR_INT_EN, 32'h3ff);
		@(posedge clk);
		chk(32'(irqReq), 32'h00f);
		wr(ELEU_ADDR_INT_EN, 32'h0);
		@(posedge clk);
		chk(32'(irqReq), 32'h0);
		rd(ELEU_ADDR_PEND, rdv);
		chk(rdv, 32'h00f);
		// Reset in mid-run returns the flags to their reset state.
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk(32'(irqReq), 32'h0);
		chk(32'(wakeEvt), 32'h0);
		rstn <= 1'b1;
		rd(ELEU_ADDR_PEND, rdv);
		chk(rdv, 32'h0);
		// A rising edge on line 6 lands in the data phase of a clearing
		// write: the edge pulse is out four edges after the pin change,
		// which is the edge that takes the write's address phase.
		wr(ELEU_ADDR_RISE, 32'h040);
		@(posedge clk);
		lines <= 10'h040;
		repeat (2) @(posedge clk);
		wr(ELEU_ADDR_PEND, 32'h3ff);
		rd(ELEU_ADDR_PEND, rdv);
		chk(rdv, 32'h040);
		conclude();
	end
endmodule
